// >>> design/i2c_bit_engine.sv
// Bit-level I2C engine: runs one condition, one bit or one byte.
// Assumes synchronised pin inputs and a quarter-period tick divider.
`timescale 1ns/1ps
module i2c_bit_engine
  import i2c_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Command
  input  wire op_t        op_i,
  input  wire logic       go_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       ack_val_i,
  input  wire logic [7:0] divider_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      rx_byte_o,
  output logic            nack_o,
  // Pins, synchronised
  input  wire logic       sda_i,
  input  wire logic       scl_i,
  output logic            sda_oe_o,
  output logic            scl_oe_o
);
  phase_t      phase_r;
  op_t         op_r;
  logic [7:0]  tick_cnt_r;
  logic [3:0]  bit_cnt_r;
  logic [8:0]  shift_r;
  logic        tick;
  logic        last_bit;
  logic        sample_r;
  logic        hold_scl_r;
  logic        hold_sda_r;
  logic        bit_sda_r;

  assign tick     = (tick_cnt_r == 8'h00);
  assign last_bit = (bit_cnt_r == 4'h0);
  assign busy_o   = (phase_r != ST_IDLE);

  always_ff @(posedge clk_i) begin
    if (reset_i || phase_r == ST_IDLE || tick) begin
      tick_cnt_r <= divider_i;
    end else if (!(phase_r == ST_Q2 && !scl_i)) begin
      tick_cnt_r <= tick_cnt_r - 8'h01;
    end
  end

  // Sequencer over four quarters per bit
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase_r   <= ST_IDLE;
      op_r      <= OP_NONE;
      bit_cnt_r <= 4'h0;
      shift_r   <= 9'h000;
      done_o    <= 1'b0;
      nack_o    <= 1'b0;
      rx_byte_o <= 8'h00;
      sample_r  <= 1'b1;
    end else begin
      done_o <= 1'b0;
      if (phase_r == ST_IDLE) begin
        if (go_i) begin
          phase_r <= ST_Q0;
          op_r    <= op_i;
          unique case (op_i)
            OP_XMIT: begin
              bit_cnt_r <= 4'h8;
              shift_r   <= {tx_byte_i, 1'b1};
            end
            OP_RECV: begin
              bit_cnt_r <= 4'h7;
              shift_r   <= 9'h1FF;
            end
            OP_ACK: begin
              bit_cnt_r <= 4'h0;
              shift_r   <= {ack_val_i, 8'hFF};
            end
            default: begin
              bit_cnt_r <= 4'h0;
              shift_r   <= 9'h1FF;
            end
          endcase
        end
      end else if (tick) begin
        unique case (phase_r)
          ST_Q0: phase_r <= ST_Q1;
          ST_Q1: phase_r <= ST_Q2;
          ST_Q2: begin
            phase_r  <= ST_Q3;
            sample_r <= sda_i;
          end
          // Shift at the end of the high half so the next bit waits for SCL low
          ST_Q3: begin
            if (last_bit) begin
              phase_r <= ST_IDLE;
              done_o  <= 1'b1;
              if (op_r == OP_XMIT) begin
                nack_o <= sample_r;
              end
              if (op_r == OP_RECV) begin
                rx_byte_o <= {shift_r[6:0], sample_r};
              end
            end else begin
              phase_r   <= ST_Q0;
              bit_cnt_r <= bit_cnt_r - 4'h1;
              shift_r   <= {shift_r[7:0], sample_r};
            end
          end
          default: phase_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Between operations SCL stays low after anything but a stop, so that
  // SDA never moves while SCL is high except in a start or stop condition
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hold_scl_r <= 1'b0;
      hold_sda_r <= 1'b0;
      bit_sda_r  <= 1'b0;
    end else if (phase_r == ST_IDLE) begin
      bit_sda_r <= hold_sda_r;
    end else if (tick && phase_r == ST_Q0) begin
      bit_sda_r <= !shift_r[8];
    end else if (tick && phase_r == ST_Q3 && last_bit) begin
      hold_scl_r <= (op_r != OP_STOP);
      hold_sda_r <= (op_r == OP_START) || (op_r == OP_RSTART) ||
                    ((op_r != OP_STOP) && bit_sda_r);
    end
  end

  // Pin drive per operation and quarter; data moves in the middle of SCL low
  always_comb begin
    sda_oe_o = hold_sda_r;
    scl_oe_o = hold_scl_r;
    if (busy_o) begin
      unique case (op_r)
        OP_START: begin
          sda_oe_o = (phase_r == ST_Q2) || (phase_r == ST_Q3);
          scl_oe_o = (phase_r == ST_Q3);
        end
        OP_RSTART: begin
          sda_oe_o = (phase_r == ST_Q3);
          scl_oe_o = (phase_r == ST_Q0);
        end
        OP_STOP: begin
          sda_oe_o = (phase_r == ST_Q0) || (phase_r == ST_Q1);
          scl_oe_o = (phase_r == ST_Q0);
        end
        OP_XMIT, OP_RECV, OP_ACK: begin
          sda_oe_o = bit_sda_r;
          scl_oe_o = (phase_r == ST_Q0) || (phase_r == ST_Q1);
        end
        default: begin
          sda_oe_o = hold_sda_r;
          scl_oe_o = hold_scl_r;
        end
      endcase
    end
  end
endmodule

// >>> design/i2c_master_sequence_control.sv
// I2C master sequence control register and its AXI4-Lite slave.
// Assumes SDA/SCL are open drain, resolved outside; pins are asynchronous.
`timescale 1ns/1ps
module i2c_master_sequence_control
  import i2c_seq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // AXI4-Lite write address and data
  input  wire logic [11:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // I2C pins
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  // Interrupt
  output logic             irq_o
);
  logic [7:0]       cmd_r;
  logic             ack_val_r;
  logic             ack_stat_r;
  logic             general_call_irq_enable_r;
  logic [7:0]       buf_r;
  logic [7:0]       div_r;
  logic             xmit_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [1:0]       sda_sync_r;
  logic [1:0]       scl_sync_r;
  logic             aw_hold_r;
  logic             w_hold_r;
  logic [11:0]      awaddr_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             idle;
  logic             wr_fire;
  logic             wr_ctrl;
  logic             wr_buf;
  logic             wr_div;
  logic             wr_mask;
  logic             wr_istat;
  logic             eng_busy;
  logic             eng_done;
  logic             eng_nack;
  logic [7:0]       eng_rx;
  logic             eng_go;
  op_t              eng_op;
  op_t              run_op_r;
  logic [IRQ_W-1:0] irq_evt;

  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    reg_index = addr[9:2];
  endfunction

  function automatic logic known_index(input logic [7:0] idx);
    known_index = (idx >= IDX_SEQ_CTRL) && (idx <= IDX_DIVIDER);
  endfunction

  function automatic logic wr_sel(input logic fire, input logic [3:0] strb,
                                  input logic [11:0] addr, input logic [7:0] idx);
    wr_sel = fire && strb[0] && (reg_index(addr) == idx);
  endfunction

  assign idle = !xmit_r && (cmd_r[BIT_ACKGO:BIT_START] == 5'h00);

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sda_sync_r <= 2'b11;
      scl_sync_r <= 2'b11;
    end else begin
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_sync_r <= {scl_sync_r[0], scl_i};
    end
  end

  // AXI write channel capture, either order
  assign s_axi_awready_o = !aw_hold_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_hold_r && !s_axi_bvalid_o;
  assign wr_fire         = aw_hold_r && w_hold_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr_i;
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata_i;
        wstrb_r  <= s_axi_wstrb_i;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= known_index(reg_index(awaddr_r)) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Register writes need byte lane 0
  assign wr_ctrl  = wr_sel(wr_fire, wstrb_r, awaddr_r, IDX_SEQ_CTRL);
  assign wr_buf   = wr_sel(wr_fire, wstrb_r, awaddr_r, IDX_DATA_BUF);
  assign wr_div   = wr_sel(wr_fire, wstrb_r, awaddr_r, IDX_DIVIDER);
  assign wr_mask  = wr_sel(wr_fire, wstrb_r, awaddr_r, IDX_IRQ_MASK);
  assign wr_istat = wr_sel(wr_fire, wstrb_r, awaddr_r, IDX_IRQ_STAT);

  // Engine launch: buffer write starts a transmit, else one command bit
  always_comb begin
    eng_op = OP_NONE;
    if (xmit_r) begin
      eng_op = OP_XMIT;
    end else if (cmd_r[BIT_START]) begin
      eng_op = OP_START;
    end else if (cmd_r[BIT_RSTART]) begin
      eng_op = OP_RSTART;
    end else if (cmd_r[BIT_STOP]) begin
      eng_op = OP_STOP;
    end else if (cmd_r[BIT_RECV]) begin
      eng_op = OP_RECV;
    end else if (cmd_r[BIT_ACKGO]) begin
      eng_op = OP_ACK;
    end
  end
  assign eng_go = !eng_busy && !eng_done && (run_op_r == OP_NONE) && (eng_op != OP_NONE);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      run_op_r <= OP_NONE;
    end else if (eng_go) begin
      run_op_r <= eng_op;
    end else if (eng_done) begin
      run_op_r <= OP_NONE;
    end
  end

  // Control bits
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_r      <= SEQ_CTRL_RST;
      ack_val_r  <= 1'b0;
      general_call_irq_enable_r     <= 1'b0;
    end else begin
      // Acknowledge value and general-call bit take every write, busy or not
      if (wr_ctrl) begin
        ack_val_r <= wdata_r[BIT_ACKVAL];
        general_call_irq_enable_r    <= wdata_r[BIT_GENERAL_CALL_IRQ_ENABLE];
      end
      if (eng_done) begin
        unique case (run_op_r)
          OP_START:  cmd_r[BIT_START]  <= 1'b0;
          OP_RSTART: cmd_r[BIT_RSTART] <= 1'b0;
          OP_STOP:   cmd_r[BIT_STOP]   <= 1'b0;
          OP_RECV:   cmd_r[BIT_RECV]   <= 1'b0;
          OP_ACK:    cmd_r[BIT_ACKGO]  <= 1'b0;
          default:   cmd_r[BIT_START]  <= cmd_r[BIT_START];
        endcase
      end else if (wr_ctrl && idle) begin
        cmd_r[BIT_ACKGO:BIT_START] <= wdata_r[BIT_ACKGO:BIT_START];
      end
    end
  end

  // Buffer and transmit-in-progress
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      buf_r      <= 8'h00;
      xmit_r     <= 1'b0;
      ack_stat_r <= 1'b0;
    end else begin
      if (wr_buf && idle) begin
        buf_r  <= wdata_r[7:0];
        xmit_r <= 1'b1;
      end else if (eng_done && run_op_r == OP_XMIT) begin
        xmit_r     <= 1'b0;
        ack_stat_r <= eng_nack;
      end else if (eng_done && run_op_r == OP_RECV) begin
        buf_r <= eng_rx;
      end
    end
  end

  // Divider and interrupt registers
  assign irq_evt[IRQ_DONE] = eng_done;
  assign irq_evt[IRQ_NACK] = eng_done && run_op_r == OP_XMIT && eng_nack;
  assign irq_evt[IRQ_COLL] = wr_buf && !idle;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_r      <= DIV_RST;
      irq_mask_r <= '0;
      irq_stat_r <= '0;
    end else begin
      if (wr_div) begin
        div_r <= wdata_r[7:0];
      end
      if (wr_mask) begin
        irq_mask_r <= wdata_r[IRQ_W-1:0];
      end
      // Set beats clear: an event in the clearing cycle stays visible
      if (wr_istat) begin
        irq_stat_r <= (irq_stat_r & ~wdata_r[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // AXI read
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= known_index(reg_index(s_axi_araddr_i)) ? RESP_OKAY : RESP_SLVERR;
      unique case (reg_index(s_axi_araddr_i))
        IDX_SEQ_CTRL: s_axi_rdata_o <= {24'h000000, general_call_irq_enable_r, ack_stat_r, ack_val_r,
                                        cmd_r[BIT_ACKGO:BIT_START]};
        IDX_DATA_BUF: s_axi_rdata_o <= {24'h000000, buf_r};
        IDX_STATUS:   s_axi_rdata_o <= {30'h00000000, !idle, xmit_r};
        IDX_IRQ_STAT: s_axi_rdata_o <= {29'h00000000, irq_stat_r};
        IDX_IRQ_MASK: s_axi_rdata_o <= {29'h00000000, irq_mask_r};
        IDX_DIVIDER:  s_axi_rdata_o <= {24'h000000, div_r};
        default:      s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // The engine sees the pins only through the two-stage synchronisers
  i2c_bit_engine u_engine (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .op_i      (eng_op),
    .go_i      (eng_go),
    .tx_byte_i (buf_r),
    .ack_val_i (ack_val_r),
    .divider_i (div_r),
    .busy_o    (eng_busy),
    .done_o    (eng_done),
    .rx_byte_o (eng_rx),
    .nack_o    (eng_nack),
    .sda_i     (sda_sync_r[1]),
    .scl_i     (scl_sync_r[1]),
    .sda_oe_o  (sda_oe_o),
    .scl_oe_o  (scl_oe_o)
  );

  // Open drain: the pads only ever pull low
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
endmodule

// >>> design/i2c_seq_pkg.sv
// Constants for the I2C master sequence control block.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
package i2c_seq_pkg;
  // Register index (printed offset, not a multiple of four)
  localparam logic [7:0] IDX_SEQ_CTRL  = 8'h91;
  localparam logic [7:0] IDX_DATA_BUF  = 8'h92;
  localparam logic [7:0] IDX_STATUS    = 8'h93;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h94;
  localparam logic [7:0] IDX_IRQ_MASK  = 8'h95;
  localparam logic [7:0] IDX_DIVIDER   = 8'h96;
  localparam int         ADDR_W        = 12;

  // Control register field positions
  localparam int BIT_START   = 0;
  localparam int BIT_RSTART  = 1;
  localparam int BIT_STOP    = 2;
  localparam int BIT_RECV    = 3;
  localparam int BIT_ACKGO   = 4;
  localparam int BIT_ACKVAL  = 5;
  localparam int BIT_SLAVE_ACK_STATUS = 6;
  localparam int BIT_GENERAL_CALL_IRQ_ENABLE    = 7;

  // Interrupt status bits
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_NACK    = 1;
  localparam int IRQ_COLL    = 2;
  localparam int IRQ_W       = 3;

  localparam logic [7:0]  SEQ_CTRL_RST = 8'h00;
  localparam logic [7:0]  DIV_RST      = 8'hF9;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Quarter bit period: 2.5 us at 10 ns for 100 kHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int QUARTER_NS    = 2500;
  localparam int QUARTER_CYC   = QUARTER_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_Q0     = 4'h1,
    ST_Q1     = 4'h3,
    ST_Q2     = 4'h2,
    ST_Q3     = 4'h6
  } phase_t;

  typedef enum logic [2:0] {
    OP_NONE   = 3'h0,
    OP_START  = 3'h1,
    OP_RSTART = 3'h3,
    OP_STOP   = 3'h2,
    OP_RECV   = 3'h6,
    OP_ACK    = 3'h7,
    OP_XMIT   = 3'h5
  } op_t;
endpackage

// >>> tb/i2c_master_sequence_control_properties.sv
// Bus and pin properties of the sequence control block.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module i2c_seq_props
  import i2c_seq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        s_axi_awvalid_i,
  input  wire logic        s_axi_awready_o,
  input  wire logic        s_axi_wvalid_i,
  input  wire logic        s_axi_wready_o,
  input  wire logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic        s_axi_arvalid_i,
  input  wire logic        s_axi_arready_o,
  input  wire logic [31:0] s_axi_rdata_o,
  input  wire logic [1:0]  s_axi_rresp_o,
  input  wire logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        sda_o,
  input  wire logic        scl_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_ar_rvalid;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_ar_rvalid: assert property (p_ar_rvalid) else $error("read answer late");
  property p_rvalid_hold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read answer dropped");
  property p_no_ar_busy;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_no_ar_busy: assert property (p_no_ar_busy) else $error("read taken while answering");
  property p_bvalid;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##[1:2] s_axi_bvalid_o;
  endproperty
  a_bvalid: assert property (p_bvalid) else $error("write answer late");
  property p_bvalid_hold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");
  property p_err_zero;
    s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR |-> s_axi_rdata_o == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_upper_zero;
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_pins_low;
    sda_o == 1'b0 && scl_o == 1'b0;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin drives high");
endmodule

bind i2c_master_sequence_control i2c_seq_props chk_u (
  .clk_i(clk_i), .reset_i(reset_i), .s_axi_awvalid_i(s_axi_awvalid_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
  .s_axi_rresp_o(s_axi_rresp_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .s_axi_rready_i(s_axi_rready_i), .sda_o(sda_o), .scl_o(scl_o));

// >>> tb/i2c_slave_model.sv
// Behavioural I2C slave: shifts bits in on SCL rise, acks byte when enabled.
// Assumes SDA and SCL are resolved open-drain lines with pull-ups.
`timescale 1ns/1ps
module i2c_slave_model (
  // Bus lines
  input  wire logic       sda_i,
  input  wire logic       scl_i,
  // Control and observation
  input  wire logic       ack_en_i,
  output logic            sda_oe_o,
  output logic [7:0]      byte_o,
  output logic            last_bit_o
);
  int         cnt;
  logic [7:0] sh;
  initial begin
    sda_oe_o   = 1'b0;
    cnt        = 0;
    sh         = 8'h00;
    byte_o     = 8'h00;
    last_bit_o = 1'b1;
  end
  // A start condition restarts the bit count
  always @(negedge sda_i) if (scl_i) cnt = 0;
  always @(posedge scl_i) begin
    last_bit_o = sda_i;
    sh = {sh[6:0], sda_i};
    cnt = cnt + 1;
    if (cnt == 8) byte_o = sh;
  end
  // Pull SDA low for the ninth bit, release it afterwards
  always @(negedge scl_i) begin
    sda_oe_o = (cnt == 8) && ack_en_i;
    if (cnt == 9) cnt = 0;
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the sequence control block and a slave model.
// Assumes open-drain lines with pull-ups, resolved here.
`timescale 1ns/1ps
module tb;
  import i2c_seq_pkg::*;
  logic        clk, rst, awv, wv, bry, arv, rry, s_ack, saw_st, saw_sp;
  logic        awr, wr, bv, arr, rv, sdo, sdoe, sco, scoe, irq, s_oe, lbit;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0]  br, rr, last_br;
  logic [7:0]  sbyte;
  int          num_errors, compares;
  wire         sda = !(sdoe || s_oe);
  wire         scl = !scoe;
  i2c_master_sequence_control dut_u (
    .clk_i(clk), .reset_i(rst), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
    .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br),
    .s_axi_bvalid_o(bv), .s_axi_bready_i(bry), .s_axi_araddr_i(ara),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
    .sda_i(sda), .sda_o(sdo), .sda_oe_o(sdoe), .scl_i(scl), .scl_o(sco),
    .scl_oe_o(scoe), .irq_o(irq));
  i2c_slave_model slave_u (.sda_i(sda), .scl_i(scl), .ack_en_i(s_ack),
    .sda_oe_o(s_oe), .byte_o(sbyte), .last_bit_o(lbit));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Start and stop conditions seen on the lines
  always @(negedge sda) if (scl) saw_st = 1'b1;
  always @(posedge sda) if (scl) saw_sp = 1'b1;
  task automatic final_report;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awa <= {2'b00, idx, 2'b00};
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 100);
    last_br = br;
    bry <= 1'b0;
    if (n >= 100) chk("bvalid", 1, 0);
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clk);
    ara <= {2'b00, idx, 2'b00};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 100);
    d = rd;
    r = rr;
    rry <= 1'b0;
    if (n >= 100) chk("rvalid", 1, 0);
  endtask
  task automatic wait_idle;
    logic [31:0] s, c;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd_reg(IDX_STATUS, s, r);
      rd_reg(IDX_SEQ_CTRL, c, r);
      n++;
    end while ((s[1:0] !== 2'h0 || c[4:0] !== 5'h0) && n < 300);
    if (n >= 300) chk("idle", 1, 0);
  endtask
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_reg(IDX_SEQ_CTRL, d, r);
    chk("ctrl reset", {24'h0, SEQ_CTRL_RST}, d);
    rd_reg(IDX_DIVIDER, d, r);
    chk("divider reset", {24'h0, DIV_RST}, d);
    rd_reg(8'h90, d, r);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("unmapped data", 32'h0, d);
    wr_reg(8'h90, 32'h0);
    chk("unmapped wresp", {30'h0, RESP_SLVERR}, {30'h0, last_br});
    wr_reg(IDX_SEQ_CTRL, 32'h80);
    rd_reg(IDX_SEQ_CTRL, d, r);
    chk("general_call_irq_enable stored", 32'h80, d);
    $display("test reset done");
  endtask
  task automatic t_start;
    logic [31:0] d;
    logic [1:0]  r;
    wr_reg(IDX_DIVIDER, 32'h1);
    saw_st = 1'b0;
    wr_reg(IDX_SEQ_CTRL, 32'h1);
    wait_idle();
    chk("start seen", 1, {31'h0, saw_st});
    rd_reg(IDX_SEQ_CTRL, d, r);
    chk("start cleared", 32'h0, d);
    $display("test start done");
  endtask
  task automatic t_busy;
    logic [31:0] d;
    logic [1:0]  r;
    s_ack <= 1'b1;
    wr_reg(IDX_DATA_BUF, 32'hA5);
    wr_reg(IDX_SEQ_CTRL, 32'h24);
    rd_reg(IDX_SEQ_CTRL, d, r);
    chk("busy ctrl", 32'h20, d & 32'h3F);
    wr_reg(IDX_DATA_BUF, 32'h3C);
    rd_reg(IDX_IRQ_STAT, d, r);
    chk("collision", 32'h4, d & 32'h4);
    wait_idle();
    chk("sent byte", 32'hA5, {24'h0, sbyte});
    rd_reg(IDX_SEQ_CTRL, d, r);
    chk("ack status", 32'h0, d & 32'h40);
    wr_reg(IDX_IRQ_STAT, 32'h7);
    rd_reg(IDX_IRQ_STAT, d, r);
    chk("irq cleared", 32'h0, d);
    $display("test busy done");
  endtask
  task automatic t_nack;
    logic [31:0] d;
    logic [1:0]  r;
    s_ack <= 1'b0;
    wr_reg(IDX_DATA_BUF, 32'h5A);
    wait_idle();
    rd_reg(IDX_SEQ_CTRL, d, r);
    chk("nack status", 32'h40, d & 32'h40);
    chk("irq masked", 0, {31'h0, irq});
    wr_reg(IDX_IRQ_MASK, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq raised", 1, {31'h0, irq});
    wr_reg(IDX_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq dropped", 0, {31'h0, irq});
    wr_reg(IDX_IRQ_STAT, 32'h7);
    wr_reg(IDX_IRQ_MASK, 32'h0);
    $display("test nack done");
  endtask
  task automatic t_ack;
    logic [31:0] d;
    logic [1:0]  r;
    for (int v = 1; v >= 0; v--) begin
      wr_reg(IDX_SEQ_CTRL, 32'h8);
      wait_idle();
      wr_reg(IDX_SEQ_CTRL, 32'h10 | (v << 5));
      wait_idle();
      chk("ack bit", v, {31'h0, lbit});
      rd_reg(IDX_SEQ_CTRL, d, r);
      chk("ack ctrl", v << 5, d & 32'h3F);
    end
    $display("test ack done");
  endtask
  task automatic t_stop;
    saw_st = 1'b0;
    wr_reg(IDX_SEQ_CTRL, 32'h2);
    wait_idle();
    chk("rstart seen", 1, {31'h0, saw_st});
    saw_sp = 1'b0;
    wr_reg(IDX_SEQ_CTRL, 32'h4);
    wait_idle();
    chk("stop seen", 1, {31'h0, saw_sp});
    chk("lines free", 2'h3, {30'h0, sda, scl});
    $display("test stop done");
  endtask
  initial begin
    {awv, wv, bry, arv, rry, s_ack, saw_st, saw_sp} = 8'h00;
    {awa, ara, wd} = 56'h0;
    num_errors = 0;
    compares = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_start();
    t_busy();
    t_nack();
    t_ack();
    t_stop();
    final_report();
  end
  initial begin
    #400000;
    num_errors++;
    final_report();
  end
endmodule
